// ---- hw/nifc_pkg.sv ----
// Package: formats, stream carriers and gamma knot tables for the converter
// What this block does
// - Unsigned normalized n-bit code maps evenly onto 0.0 through 1.0.
// - Unsigned normalized value is the code divided by two to the n, minus one.
// - Gamma conversion only applies to unsigned normalized formats; others unsupported.
// - Gamma formats decode after surface read and encode before surface write.
// - Signed normalized code divided by two to the n-1, minus one.
// - Most negative signed normalized code clamps to -1.0.
// - Unsigned integer copy passes the code through, zero-extended.
// - Unsigned scaled converts to equal float, round to nearest even.
// - Signed integer copy passes the code through, sign-extended.
// - Signed scaled converts to equal float, round to nearest even.
package nifc_pkg;

	localparam int DATA_W = 32;
	localparam int WIDTH_W = 6;
	localparam int GAMMA_W = 16;
	localparam int PAT_W = 96;
	localparam int PAT_STEPS = 7;
	localparam int FRAC_OFF = -96;
	localparam int FLT_BIAS = 127;
	localparam logic [31:0] FLT_ZERO = 32'h0000_0000;
	localparam logic [31:0] FLT_ONE = 32'h3f80_0000;
	localparam logic [31:0] FLT_NEG_ONE = 32'hbf80_0000;

	typedef enum logic [2:0] {
		FMT_UNSIGNED_NORMALIZED = 3'b000,
		FMT_SIGNED_NORMALIZED = 3'b001,
		FMT_UNSIGNED_INTEGER_COPY = 3'b010,
		FMT_UNSIGNED_SCALED_TO_FLOAT = 3'b011,
		FMT_SIGNED_INTEGER_COPY = 3'b100,
		FMT_SIGNED_SCALED_TO_FLOAT = 3'b101
	} nifc_fmt_t;

	typedef struct packed {
		logic [31:0] raw;
		logic [5:0] width;
		nifc_fmt_t fmt;
		logic gamma_encoded_flag;
		logic wr_dir;
	} nifc_req_t;

	typedef struct packed {
		logic [31:0] data;
		logic is_float;
		logic unsupported;
	} nifc_rsp_t;

	typedef struct packed {
		logic [31:0] code;
		logic [5:0] width;
		nifc_fmt_t fmt;
		logic pass;
		logic unsup;
	} nifc_stage_t;

	typedef logic [16:0][15:0] nifc_knots_t;

	// Knot k holds the curve at k/16, full scale 16'hffff
	localparam nifc_knots_t GAMMA_DEC_KNOTS = {
		16'hffff, 16'hdd19, 16'hbd24, 16'ha00f, 16'h85c3, 16'h6e2d,
		16'h5938, 16'h46ca, 16'h36cb, 16'h2922, 16'h1db5, 16'h145f,
		16'h0d08, 16'h0782, 16'h03ac, 16'h0152, 16'h0000};
	localparam nifc_knots_t GAMMA_ENC_KNOTS = {
		16'hffff, 16'hf8d5, 16'hf161, 16'he99c, 16'he17d, 16'hd8f5,
		16'hcff7, 16'hc66d, 16'hbc40, 16'hb14d, 16'ha565, 16'h9844,
		16'h897f, 16'h785f, 16'h6379, 16'h46fc, 16'h0000};

endpackage

// ---- hw/nifc_gamma.sv ----
// Piecewise-linear gamma curve over sixteen equal segments
`timescale 1ns/1ps
module nifc_gamma #(
	parameter nifc_pkg::nifc_knots_t KNOTS = nifc_pkg::GAMMA_DEC_KNOTS
) (
	input wire logic [15:0] x,
	output logic [15:0] y
);

	wire [3:0] seg = x[15:12];
	wire [11:0] frac = x[11:0];
	wire [4:0] seg_hi = {1'b0, seg} + 5'h01;
	wire [15:0] k_lo = KNOTS[seg];
	wire [15:0] k_hi = KNOTS[seg_hi];
	// Knots rise monotonically, so the span never wraps
	wire [15:0] span = k_hi - k_lo;
	wire [27:0] prod = span * frac;

	// gamma_encoded_flag curve interpolation
	// Segments step by x/65536, so the top code is pinned to full scale
	assign y = (x == 16'hffff) ? KNOTS[16] : 16'(k_lo + prod[27:12]);

endmodule

// ---- hw/nifc_to_float.sv ----
// Fixed-point magnitude to single-precision float, round to nearest even
`timescale 1ns/1ps
module nifc_to_float #(
	parameter int W = 96
) (
	input wire logic neg,
	input wire logic [W-1:0] mag,
	input wire logic sticky,
	input wire logic signed [8:0] off,
	output logic [31:0] flt
);

	localparam int PW = $clog2(W);

	logic [PW-1:0] pos;
	always_comb begin
		pos = '0;
		for (int i = 0; i < W; i++) begin
			if (mag[i]) begin
				pos = PW'(i);
			end
		end
	end

	wire [PW-1:0] lsh = PW'(W - 1) - pos;
	wire [W-1:0] norm = mag << lsh;
	wire [23:0] m24 = norm[W-1 -: 24];
	wire guard = norm[W-25];
	wire rest = (|norm[W-26:0]) | sticky;
	// ties go to the even mantissa
	wire up = guard & (rest | m24[0]);
	wire [24:0] mr = {1'b0, m24} + {24'h0, up};
	wire [10:0] e_raw = 11'(nifc_pkg::FLT_BIAS) + 11'(pos) + 11'(off) + {10'h0, mr[24]};
	wire [22:0] frac = mr[24] ? mr[23:1] : mr[22:0];

	assign flt = (mag == '0) ? nifc_pkg::FLT_ZERO : {neg, e_raw[7:0], frac};

endmodule

// ---- hw/nifc_core.sv ----
// Two-stage stream converter from surface channel codes to pipeline values
`timescale 1ns/1ps
module nifc_core (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire nifc_pkg::nifc_req_t in_req,
	output logic out_valid,
	input wire logic out_ready,
	output nifc_pkg::nifc_rsp_t out_rsp
);

	// Repeating the code forever gives code/(2^n-1) exactly as a binary fraction
	function automatic logic [95:0] rep_pat(input logic [31:0] c, input logic [5:0] n);
		logic [95:0] p;
		p = {c, 64'h0} << (6'd32 - n);
		for (int i = 0; i < nifc_pkg::PAT_STEPS; i++) begin
			p = p | (p >> (int'(n) << i));
		end
		return p;
	endfunction

	function automatic logic [31:0] width_mask(input logic [5:0] n);
		logic [32:0] m;
		m = (33'h1 << n) - 33'h1;
		return m[31:0];
	endfunction

	// Stage A: width checks and gamma

	nifc_pkg::nifc_stage_t a_r;
	nifc_pkg::nifc_stage_t a_nxt;
	logic a_valid_r;

	wire [5:0] in_w = in_req.width;
	wire in_w_ok = (in_w != 6'h00) && (in_w <= 6'd32);
	wire [31:0] in_mask = in_w_ok ? width_mask(in_w) : 32'h0;
	wire [31:0] in_code = in_req.raw & in_mask;
	wire in_is_un = in_req.fmt == nifc_pkg::FMT_UNSIGNED_NORMALIZED;
	wire in_gamma = in_req.gamma_encoded_flag;

	wire gamma_bad = in_gamma && (!in_is_un || (in_w > 6'(nifc_pkg::GAMMA_W)));
	wire in_unsup = !in_w_ok || gamma_bad;
	wire gamma_rd = in_gamma && !gamma_bad && !in_req.wr_dir;
	wire gamma_wr = in_gamma && !gamma_bad && in_req.wr_dir;

	wire [95:0] in_pat = rep_pat(in_code, in_w);
	wire [15:0] dec_x = in_pat[95:80];
	wire [15:0] dec_y;
	wire [15:0] enc_y;

	nifc_gamma #(
		.KNOTS(nifc_pkg::GAMMA_DEC_KNOTS)
	) u_dec (
		.x(dec_x),
		.y(dec_y)
	);

	nifc_gamma #(
		.KNOTS(nifc_pkg::GAMMA_ENC_KNOTS)
	) u_enc (
		.x(in_req.raw[15:0]),
		.y(enc_y)
	);

	// Write side takes a 16-bit linear fraction; quantize to n bits with rounding
	wire [4:0] q_sh = 5'(6'd16 - in_w);
	wire [15:0] q_trunc = enc_y >> q_sh;
	wire [15:0] q_half = (q_sh == 5'h00) ? 16'h0 : 16'(enc_y >> (q_sh - 5'h01));
	wire q_up = q_half[0] && (q_trunc != in_mask[15:0]);
	wire [15:0] q_code = q_trunc + {15'h0, q_up};

	always_comb begin
		a_nxt.code = in_code;
		a_nxt.width = in_w;
		a_nxt.fmt = in_req.fmt;
		a_nxt.pass = 1'b0;
		a_nxt.unsup = in_unsup;
		if (in_unsup) begin
			a_nxt.code = 32'h0;
		end else if (gamma_rd) begin
			a_nxt.code = {16'h0, dec_y};
			a_nxt.width = 6'(nifc_pkg::GAMMA_W);
		end else if (gamma_wr) begin
			a_nxt.code = {16'h0, q_code};
			a_nxt.pass = 1'b1;
		end
	end

	// Handshake: each stage stalls only while its successor is full and blocked

	nifc_pkg::nifc_rsp_t out_r;
	nifc_pkg::nifc_rsp_t out_nxt;
	logic out_valid_r;

	wire b_ready = !out_valid_r || out_ready;
	wire a_ready = !a_valid_r || b_ready;
	wire a_load = in_valid && a_ready;
	wire b_load = a_valid_r && b_ready;

	assign in_ready = a_ready;
	assign out_valid = out_valid_r;
	assign out_rsp = out_r;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			a_valid_r <= 1'b0;
			a_r <= '0;
		end else if (a_ready) begin
			a_valid_r <= in_valid;
			if (in_valid) begin
				a_r <= a_nxt;
			end
		end
	end

	// Stage B: interpretation and float conversion

	wire [5:0] b_w = a_r.width;
	wire [31:0] b_mask = a_r.unsup ? 32'h0 : width_mask(b_w);
	wire [31:0] b_msb = b_mask ^ (b_mask >> 1);
	wire [31:0] b_code = a_r.code;
	wire b_sign = |(b_code & b_msb);
	wire [31:0] b_sext = b_code | (b_sign ? ~b_mask : 32'h0);
	wire [31:0] b_mag = b_sign ? (32'h0 - b_sext) : b_sext;
	wire [5:0] b_k = (b_w == 6'h00) ? 6'h00 : (b_w - 6'h01);
	wire b_most_neg = (b_code == b_msb) && (b_msb != 32'h0);

	wire b_un = (a_r.fmt == nifc_pkg::FMT_UNSIGNED_NORMALIZED) && !a_r.pass && !a_r.unsup;
	wire b_sn = (a_r.fmt == nifc_pkg::FMT_SIGNED_NORMALIZED) && !a_r.unsup;
	wire b_uc = (a_r.fmt == nifc_pkg::FMT_UNSIGNED_INTEGER_COPY) && !a_r.unsup;
	wire b_us = (a_r.fmt == nifc_pkg::FMT_UNSIGNED_SCALED_TO_FLOAT) && !a_r.unsup;
	wire b_sc = (a_r.fmt == nifc_pkg::FMT_SIGNED_INTEGER_COPY) && !a_r.unsup;
	wire b_ss = (a_r.fmt == nifc_pkg::FMT_SIGNED_SCALED_TO_FLOAT) && !a_r.unsup;

	wire [95:0] un_pat = rep_pat(b_code, b_w);
	wire [95:0] sn_pat = rep_pat(b_mag, b_k);

	logic f_neg;
	logic [95:0] f_mag;
	logic f_sticky;
	logic signed [8:0] f_off;
	wire [31:0] f_out;

	// repeating fraction equals code over 2^n-1
	always_comb begin
		f_neg = 1'b0;
		f_mag = {64'h0, b_code};
		f_sticky = 1'b0;
		f_off = 9'sh000;
		if (b_un) begin
			f_mag = un_pat;
			f_sticky = b_code != 32'h0;
			f_off = 9'(nifc_pkg::FRAC_OFF);
		end else if (b_sn) begin
			f_neg = b_sign;
			f_mag = sn_pat;
			f_sticky = b_mag != 32'h0;
			f_off = 9'(nifc_pkg::FRAC_OFF);
		end else if (b_ss) begin
			f_neg = b_sign;
			f_mag = {64'h0, b_mag};
		end
	end

	nifc_to_float #(
		.W(nifc_pkg::PAT_W)
	) u_flt (
		.neg(f_neg),
		.mag(f_mag),
		.sticky(f_sticky),
		.off(f_off),
		.flt(f_out)
	);

	always_comb begin
		out_nxt.data = f_out;
		out_nxt.is_float = 1'b1;
		out_nxt.unsupported = a_r.unsup;
		if (a_r.unsup) begin
			out_nxt.data = 32'h0;
			out_nxt.is_float = 1'b0;
		end else if (a_r.pass || b_uc) begin
			out_nxt.data = b_code;
			out_nxt.is_float = 1'b0;
		end else if (b_sc) begin
			out_nxt.data = b_sext;
			out_nxt.is_float = 1'b0;
		end else if (b_sn && b_most_neg) begin
			out_nxt.data = nifc_pkg::FLT_NEG_ONE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_valid_r <= 1'b0;
			out_r <= '0;
		end else if (b_ready) begin
			out_valid_r <= a_valid_r;
			if (a_valid_r) begin
				out_r <= out_nxt;
			end
		end
	end

	// Checks

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	a_unsigned_normalized_zero: assert property (b_load && b_un && b_code == 32'h0
		|=> out_r.data == nifc_pkg::FLT_ZERO && out_r.is_float)
		else $error("unsigned normalized zero not 0.0");

	a_unsigned_normalized_full: assert property (b_load && b_un && b_code == b_mask
		|=> out_r.data == nifc_pkg::FLT_ONE)
		else $error("unsigned normalized full code not 1.0");

	a_unsigned_normalized_third: assert property (b_load && b_un && b_w == 6'd2 && b_code == 32'h1
		|=> out_r.data == 32'h3eaa_aaab)
		else $error("two-bit code one not one third");

	a_gamma_type: assert property (a_load && in_gamma && !in_is_un
		|=> a_r.unsup)
		else $error("gamma on other format not flagged");

	a_unsup_out: assert property (b_load && a_r.unsup
		|=> out_r.unsupported && !out_r.is_float && out_r.data == 32'h0)
		else $error("unsupported result not zero integer");

	a_enc_zero: assert property (a_load && gamma_wr && in_req.raw[15:0] == 16'h0
		|=> a_r.pass && a_r.code == 32'h0)
		else $error("encoded zero linear value not zero code");

	a_gamma_dec: assert property (a_load && gamma_rd && in_code == in_mask
		|=> a_r.code == 32'h0000_ffff && a_r.width == 6'd16)
		else $error("decoded full gamma code not full scale");

	a_gamma_enc: assert property (a_load && gamma_wr && in_req.raw[15:0] == 16'hffff
		|=> a_r.pass && a_r.code == $past(in_mask))
		else $error("encoded full linear value not full code");

	a_signed_normalized_max: assert property (b_load && b_sn && b_w > 6'd1 && b_code == (b_mask >> 1)
		|=> out_r.data == nifc_pkg::FLT_ONE)
		else $error("signed normalized max not +1.0");

	a_signed_normalized_clamp: assert property (b_load && b_sn && b_most_neg
		|=> out_r.data == nifc_pkg::FLT_NEG_ONE)
		else $error("most negative code not clamped");

	a_signed_normalized_zero: assert property (b_load && b_sn && b_code == 32'h0
		|=> out_r.data == nifc_pkg::FLT_ZERO)
		else $error("signed normalized zero not 0.0");

	a_signed_normalized_nmax: assert property (b_load && b_sn && b_code == (b_msb | 32'h1)
		|=> out_r.data == nifc_pkg::FLT_NEG_ONE)
		else $error("signed normalized negative max not -1.0");

	a_usc_three: assert property (b_load && b_us && b_code == 32'h3
		|=> out_r.data == 32'h4040_0000)
		else $error("unsigned scaled three not 3.0");

	a_unsigned_integer_copy_copy: assert property (b_load && b_uc && !a_r.pass
		|=> out_r.data == $past(b_code) && !out_r.is_float)
		else $error("unsigned copy altered");

	a_usc_round: assert property (b_load && b_us && b_w == 6'd32 && b_code == 32'hffff_ffff
		|=> out_r.data == 32'h4f80_0000)
		else $error("unsigned scaled rounding wrong");

	a_signed_integer_copy_copy: assert property (b_load && b_sc
		|=> out_r.data == $past(b_sext) && !out_r.is_float)
		else $error("signed copy not sign extended");

	a_ssc_round: assert property (b_load && b_ss && b_w == 6'd32 && b_code == 32'h7fff_ffff
		|=> out_r.data == 32'h4f00_0000)
		else $error("signed scaled rounding wrong");

	a_ssc_neg: assert property (b_load && b_ss && b_w == 6'd16 && b_code == 32'h0000_fffd
		|=> out_r.data == 32'hc040_0000)
		else $error("signed scaled -3 wrong");

	a_hold_stall: assert property (out_valid && !out_ready
		|=> out_valid && $stable(out_r))
		else $error("output changed under stall");

	c_unsigned_normalized: cover property (b_load && b_un ##1 out_valid && out_ready);
	c_clamp: cover property (b_load && b_sn && b_most_neg);
	c_gamma_wr: cover property (a_load && gamma_wr);
	c_gamma_rd: cover property (a_load && gamma_rd);
	c_stall: cover property ((out_valid && !out_ready) [*2] ##1 out_ready);

endmodule

// ---- tb/nifc_sink.sv ----
// Result sink that can hold off the converter's output
`timescale 1ns/1ps
module nifc_sink (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic slow,
	output logic out_ready
);
	logic [1:0] cnt_r;
	// Slow mode takes one beat in three so results back up
	always_ff @(posedge core_clk) begin
		if (rst || cnt_r == 2'h2) begin
			cnt_r <= 2'h0;
		end else begin
			cnt_r <= cnt_r + 2'h1;
		end
	end
	assign out_ready = !slow || (cnt_r == 2'h2);
endmodule

// ---- tb/tb_nifc_core.sv ----
// Self-checking bench for the channel format converter
`timescale 1ns/1ps
module tb_nifc_core;
	localparam nifc_pkg::nifc_fmt_t UN = nifc_pkg::FMT_UNSIGNED_NORMALIZED;
	localparam nifc_pkg::nifc_fmt_t SN = nifc_pkg::FMT_SIGNED_NORMALIZED;
	localparam nifc_pkg::nifc_fmt_t UC = nifc_pkg::FMT_UNSIGNED_INTEGER_COPY;
	localparam nifc_pkg::nifc_fmt_t US = nifc_pkg::FMT_UNSIGNED_SCALED_TO_FLOAT;
	localparam nifc_pkg::nifc_fmt_t SC = nifc_pkg::FMT_SIGNED_INTEGER_COPY;
	localparam nifc_pkg::nifc_fmt_t SS = nifc_pkg::FMT_SIGNED_SCALED_TO_FLOAT;
	localparam nifc_pkg::nifc_rsp_t UNSUP = '{32'h0, 1'h0, 1'h1};
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic in_valid = 1'b0;
	logic in_ready;
	nifc_pkg::nifc_req_t in_req = '0;
	logic out_valid;
	logic out_ready;
	logic slow = 1'b0;
	nifc_pkg::nifc_rsp_t out_rsp;
	nifc_pkg::nifc_rsp_t exp_q[$];
	nifc_pkg::nifc_rsp_t hold_rsp;
	logic hold_r = 1'b0;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;

	always #20 core_clk = ~core_clk;

	nifc_core nifc_core_i (.core_clk(core_clk), .rst(rst), .in_valid(in_valid),
		.in_ready(in_ready), .in_req(in_req), .out_valid(out_valid),
		.out_ready(out_ready), .out_rsp(out_rsp));
	nifc_sink nifc_sink_i (.core_clk(core_clk), .rst(rst), .slow(slow), .out_ready(out_ready));

	task automatic final_report();
		$display("Checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input nifc_pkg::nifc_rsp_t e, nifc_pkg::nifc_rsp_t g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk_bit(input string what, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %b seen %b", what, e, g);
		end
	endtask

	function automatic nifc_pkg::nifc_req_t rq(logic [31:0] raw, logic [5:0] w,
		nifc_pkg::nifc_fmt_t f, logic g = 1'h0, logic wd = 1'h0);
		rq = '{raw, w, f, g, wd};
	endfunction

	function automatic nifc_pkg::nifc_rsp_t fl(logic [31:0] d);
		fl = '{d, 1'h1, 1'h0};
	endfunction

	function automatic nifc_pkg::nifc_rsp_t it(logic [31:0] d);
		it = '{d, 1'h0, 1'h0};
	endfunction

	// Ceiling far above the hundred or so cycles the scenarios need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			final_report();
		end
	end

	// Results leave in request order; a stalled result must not move
	always @(posedge core_clk) begin
		if (hold_r) begin
			chk_bit("valid held", 1'h1, out_valid);
			chk("result held", hold_rsp, out_rsp);
		end
		hold_r <= !rst && out_valid === 1'b1 && out_ready !== 1'b1;
		hold_rsp <= out_rsp;
		if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk_bit("spare result", 1'h0, 1'h1);
			end else begin
				chk("result", exp_q.pop_front(), out_rsp);
			end
		end
	end

	task automatic send(input nifc_pkg::nifc_req_t r, input nifc_pkg::nifc_rsp_t e);
		exp_q.push_back(e);
		in_valid <= 1'b1;
		in_req <= r;
		@(negedge core_clk);
		while (in_ready !== 1'b1) @(negedge core_clk);
		@(posedge core_clk);
	endtask

	// Idle request bits are scrambled so stale values cannot pass
	task automatic drain();
		in_valid <= 1'b0;
		in_req <= ~in_req;
		repeat (30) begin
			if (exp_q.size() != 0) @(posedge core_clk);
		end
		chk_bit("drained", 1'h1, exp_q.size() == 0);
		@(posedge core_clk);
	endtask

	task automatic t_unsigned_normalized();
		send(rq(32'h0, 6'h02, UN), fl(32'h0));
		send(rq(32'h1, 6'h02, UN), fl(32'h3eaa_aaab));
		send(rq(32'hffff_fff3, 6'h02, UN), fl(32'h3f80_0000));
		send(rq(32'hffff_ffff, 6'h20, UN), fl(32'h3f80_0000));
		send(rq(32'h3, 6'h02, UN, 1'h0, 1'h1), fl(32'h3f80_0000));
		drain();
	endtask

	task automatic t_signed_normalized();
		send(rq(32'h80, 6'h08, SN), fl(32'hbf80_0000));
		send(rq(32'h81, 6'h08, SN), fl(32'hbf80_0000));
		send(rq(32'h7f, 6'h08, SN), fl(32'h3f80_0000));
		send(rq(32'h40, 6'h08, SN), fl(32'h3f01_0204));
		send(rq(32'hc0, 6'h08, SN), fl(32'hbf01_0204));
		send(rq(32'h1, 6'h01, SN), fl(32'hbf80_0000));
		send(rq(32'h0, 6'h01, SN), fl(32'h0));
		drain();
	endtask

	task automatic t_copy();
		send(rq(32'habcd_00ff, 6'h08, UC), it(32'hff));
		send(rq(32'hffff_ffff, 6'h20, UC), it(32'hffff_ffff));
		send(rq(32'h1234_fffd, 6'h10, SC), it(32'hffff_fffd));
		send(rq(32'hffff_7ffd, 6'h10, SC), it(32'h7ffd));
		drain();
	endtask

	task automatic t_scaled();
		send(rq(32'h3, 6'h08, US), fl(32'h4040_0000));
		send(rq(32'hffff_ffff, 6'h20, US), fl(32'h4f80_0000));
		send(rq(32'h0100_0001, 6'h20, US), fl(32'h4b80_0000));
		send(rq(32'h0100_0003, 6'h20, US), fl(32'h4b80_0002));
		send(rq(32'hfffd, 6'h10, SS), fl(32'hc040_0000));
		send(rq(32'h8000_0000, 6'h20, SS), fl(32'hcf00_0000));
		send(rq(32'hfeff_ffff, 6'h20, SS), fl(32'hcb80_0000));
		drain();
	endtask

	task automatic t_gamma();
		send(rq(32'hff, 6'h08, UN, 1'h1), fl(32'h3f80_0000));
		send(rq(32'h0, 6'h08, UN, 1'h1), fl(32'h0));
		send(rq(32'hffff, 6'h08, UN, 1'h1, 1'h1), it(32'hff));
		send(rq(32'h0, 6'h08, UN, 1'h1, 1'h1), it(32'h0));
		send(rq(32'h7f, 6'h08, SN, 1'h1), UNSUP);
		send(rq(32'h3, 6'h08, US, 1'h1), UNSUP);
		send(rq(32'h1, 6'h11, UN, 1'h1), UNSUP);
		send(rq(32'h1, 6'h00, UN), UNSUP);
		send(rq(32'h1, 6'h21, UN), UNSUP);
		drain();
	endtask

	initial begin
		@(negedge core_clk);
		chk_bit("valid in reset", 1'h0, out_valid);
		repeat (9) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_unsigned_normalized();
		t_signed_normalized();
		t_copy();
		slow <= 1'b1;
		t_scaled();
		t_gamma();
		t_copy();
		final_report();
	end
endmodule
